// *** hdl/mcc_codec.v ***
// Purpose : manchester encoder, decoder and collision translator
// Assumes : all pins synchronous to ref_clk_in; attachment-unit mode by pin
// Notes   : two samples per bit, so edge jitter must stay under half a sample
//           the abort flag lasts one cycle; the controller keeps the backoff state
//           abort and collision indicator act only in attachment-unit mode
`timescale 1ns/1ps
`include "mcc_defs.vh"
module mcc_codec
(
   input  wire       ref_clk_in,
   input  wire       rst_in,
   input  wire       aui_mode_in,
   input  wire       tx_en_in,
   input  wire       tx_data_in,
   input  wire       rx_pos_in,
   input  wire       rx_neg_in,
   input  wire       collision_pair_pos_in,
   input  wire       collision_pair_neg_in,
   output reg        tx_clk_out,
   output reg        tx_pos_out,
   output reg        tx_neg_out,
   output reg        rx_clk_out,
   output reg        rx_data_out,
   output reg        rx_valid_out,
   output reg        carrier_out,
   output reg        collision_out,
   output reg        tx_abort_out,
   output reg        col_led_out
);

   // ----------------------------------------------------------------------
   // clock divider
   // ----------------------------------------------------------------------
   // tx_clk_out rises when tx_phase_r goes to 1; the bit is taken on that
   // same cycle so the controller sees data set up on its falling edge
   reg        tx_phase_r;
   always @(posedge ref_clk_in)
   begin
      if (rst_in)
      begin
         tx_phase_r <= 1'b0;
         tx_clk_out <= 1'b0;
      end
      else
      begin
         tx_phase_r <= ~tx_phase_r;
         tx_clk_out <= ~tx_phase_r;
      end
   end

   // ----------------------------------------------------------------------
   // encoder
   // ----------------------------------------------------------------------
   reg        tx_bit_r;
   reg        tx_busy_r;
   wire       col_tone;
   wire       abort_now;

   assign abort_now = aui_mode_in & collision_out;

   always @(posedge ref_clk_in)
   begin
      if (rst_in)
      begin
         tx_bit_r     <= 1'b0;
         tx_busy_r    <= 1'b0;
         tx_pos_out   <= 1'b0;
         tx_neg_out   <= 1'b0;
         tx_abort_out <= 1'b0;
      end
      else
      begin
         tx_abort_out <= abort_now & tx_busy_r;
         if (abort_now | ~tx_en_in)
         begin
            // in attachment-unit mode a collision drops the frame at once; the controller reschedules
            tx_busy_r  <= 1'b0;
            tx_pos_out <= 1'b0;
            tx_neg_out <= 1'b0;
         end
         else if (~tx_phase_r)
         begin
            // first half of a bit carries the complement
            tx_busy_r  <= 1'b1;
            tx_bit_r   <= tx_data_in;
            tx_pos_out <= ~tx_data_in;
            tx_neg_out <= tx_data_in;
         end
         else if (tx_busy_r)
         begin
            tx_pos_out <= tx_bit_r;
            tx_neg_out <= ~tx_bit_r;
         end
      end
   end

   // ----------------------------------------------------------------------
   // decoder
   // ----------------------------------------------------------------------
   // the half-bit phase alternates while the line is busy; a pair of equal
   // samples can only straddle a bit boundary, so it re-locks the phase, and
   // runs of equal bits (a plain 10 MHz square wave) still decode
   reg        rx_last_r;
   reg        rx_half_r;
   reg  [2:0] lock_cnt_r;
   reg  [2:0] gap_cnt_r;
   wire       rx_lvl;
   wire       rx_sig;
   wire       rx_edge;
   wire       mid_edge;

   assign rx_lvl   = rx_pos_in & ~rx_neg_in;
   assign rx_sig   = rx_pos_in ^ rx_neg_in;
   assign rx_edge  = rx_sig & (rx_lvl != rx_last_r);
   assign mid_edge = rx_edge & rx_half_r;

   always @(posedge ref_clk_in)
   begin
      if (rst_in)
      begin
         rx_last_r    <= 1'b0;
         rx_half_r    <= 1'b0;
         lock_cnt_r   <= 3'h0;
         gap_cnt_r    <= 3'h0;
         carrier_out  <= 1'b0;
         rx_clk_out   <= 1'b0;
         rx_data_out  <= 1'b0;
         rx_valid_out <= 1'b0;
      end
      else
      begin
         rx_last_r  <= rx_lvl;
         rx_clk_out <= mid_edge;
         // whole-sample re-lock on every equal pair absorbs edge wander
         if (~rx_sig)
         begin
            // idle line: the first busy sample is taken as a first half
            rx_half_r <= 1'b0;
         end
         else if (rx_edge & rx_half_r)
         begin
            rx_half_r <= 1'b0;
         end
         else
         begin
            rx_half_r <= 1'b1;
         end
         if (mid_edge)
         begin
            rx_data_out <= rx_lvl;
            gap_cnt_r   <= 3'h0;
            carrier_out <= 1'b1;
            if (lock_cnt_r != `MCC_LOCK_BITS)
            begin
               lock_cnt_r <= lock_cnt_r + 3'h1;
            end
            else
            begin
               rx_valid_out <= 1'b1;
            end
         end
         else if (gap_cnt_r >= (`MCC_EOF_CYC - 1))
         begin
            carrier_out  <= 1'b0;
            rx_valid_out <= 1'b0;
            lock_cnt_r   <= 3'h0;
         end
         else
         begin
            gap_cnt_r <= gap_cnt_r + 3'h1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // collision translator
   // ----------------------------------------------------------------------
   // activity follows the transmit request, not tx_busy_r: an abort clears
   // tx_busy_r while the controller may still hold its request
   wire       net_busy;

   assign net_busy = tx_en_in | carrier_out;

   mcc_tone_det u_col_det
   (
      .clk_in     (ref_clk_in),
      .rst_in     (rst_in),
      .pos_in     (collision_pair_pos_in),
      .neg_in     (collision_pair_neg_in),
      .active_out (col_tone)
   );

   always @(posedge ref_clk_in)
   begin
      if (rst_in)
      begin
         collision_out <= 1'b0;
         col_led_out   <= 1'b0;
      end
      else
      begin
         collision_out <= col_tone;
         // heartbeat follows the frame, so tx is idle then; with carrier_out also low the led stays off
         col_led_out   <= aui_mode_in & col_tone & net_busy;
      end
   end

endmodule

// *** hdl/mcc_defs.vh ***
// Purpose : constants for the manchester codec with collision translator
// Assumes : 20 MHz reference clock, 10 Mbit/s line rate
// Notes   : times are kept in ns; cycle counts derive from them
`ifndef MCC_DEFS_VH
`define MCC_DEFS_VH

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define MCC_CLK_NS         50
`define MCC_BIT_NS         100
`define MCC_TX_DIV         2
`define MCC_BIT_CYC        (`MCC_BIT_NS / `MCC_CLK_NS)
`define MCC_JITTER_NS      20
// bits decoded after frame start before data is declared valid
`define MCC_LOCK_BITS      6
// a mid-bit transition is expected every bit; missing for this long = end
`define MCC_EOF_NS         150
`define MCC_EOF_CYC        ((`MCC_EOF_NS + `MCC_CLK_NS - 1) / `MCC_CLK_NS)
// collision pair: transitions in a row to accept, quiet time to drop
`define MCC_COL_ON_CNT     4
`define MCC_COL_OFF_NS     200
`define MCC_COL_OFF_CYC    (`MCC_COL_OFF_NS / `MCC_CLK_NS)

`endif

// *** hdl/mcc_tone_det.v ***
// Purpose : qualifies a toggling differential pair as a valid signal
// Assumes : pair sampled on the reference clock, 10 MHz tone toggles every cycle
// Notes   : single edges from noise do not qualify; quiet gap drops it
`timescale 1ns/1ps
`include "mcc_defs.vh"
module mcc_tone_det
(
   input  wire       clk_in,
   input  wire       rst_in,
   input  wire       pos_in,
   input  wire       neg_in,
   output reg        active_out
);

   reg        last_r;
   reg  [2:0] run_r;
   reg  [3:0] quiet_r;
   wire       lvl;
   wire       edge_seen;

   assign lvl       = pos_in & ~neg_in;
   assign edge_seen = (lvl != last_r) && (pos_in != neg_in);

   always @(posedge clk_in)
   begin
      if (rst_in)
      begin
         last_r     <= 1'b0;
         run_r      <= 3'h0;
         quiet_r    <= 4'h0;
         active_out <= 1'b0;
      end
      else
      begin
         last_r <= lvl;
         if (edge_seen)
         begin
            quiet_r <= 4'h0;
            if (run_r != 3'h7)
            begin
               run_r <= run_r + 3'h1;
            end
            if (run_r >= (`MCC_COL_ON_CNT - 1))
            begin
               active_out <= 1'b1;
            end
         end
         else if (quiet_r >= (`MCC_COL_OFF_CYC - 1))
         begin
            run_r      <= 3'h0;
            active_out <= 1'b0;
         end
         else
         begin
            quiet_r <= quiet_r + 4'h1;
         end
      end
   end

endmodule

// *** tb/mcc_codec_assertions.sv ***
// Purpose: port checks for the manchester codec
// Assumes: one clock domain, sync active-high reset
// Notes: quiet spans of 8 cycles cover detector and register latency
`timescale 1ns/1ps
module mcc_codec_assertions
(
   input wire ref_clk_in,
   input wire rst_in,
   input wire aui_mode_in,
   input wire tx_en_in,
   input wire tx_data_in,
   input wire rx_pos_in,
   input wire collision_pair_pos_in,
   input wire tx_clk_out,
   input wire tx_pos_out,
   input wire tx_neg_out,
   input wire rx_clk_out,
   input wire carrier_out,
   input wire collision_out,
   input wire tx_abort_out,
   input wire col_led_out
);
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   property p_div; !rst_in |=> tx_clk_out != $past(tx_clk_out); endproperty
   a_div: assert property (p_div) else $error("tx clock not halved");
   property p_idle; !tx_en_in && !tx_clk_out |=> !tx_pos_out && !tx_neg_out; endproperty
   a_idle: assert property (p_idle) else $error("idle pair not equal");
   property p_first; tx_en_in && !tx_clk_out && !collision_out |=> tx_abort_out
      || (tx_neg_out == $past(tx_data_in) && tx_pos_out != tx_neg_out); endproperty
   a_first: assert property (p_first) else $error("first half wrong");
   property p_second; tx_clk_out && tx_pos_out != tx_neg_out |=> tx_abort_out
      || (tx_pos_out == $past(tx_neg_out) && tx_neg_out == $past(tx_pos_out)); endproperty
   a_second: assert property (p_second) else $error("no mid-bit transition");
   property p_abort; tx_abort_out |=> !tx_pos_out && !tx_neg_out; endproperty
   a_abort: assert property (p_abort) else $error("pair driven during abort");
   property p_rxclk_one; rx_clk_out |=> !rx_clk_out; endproperty
   a_rxclk_one: assert property (p_rxclk_one) else $error("rx clock high too long");
   property p_led; !aui_mode_in || (!tx_en_in && !carrier_out) |=> !col_led_out; endproperty
   a_led: assert property (p_led) else $error("indicator lit without activity");
   property p_coloff; $stable(collision_pair_pos_in) [*8] |-> !collision_out; endproperty
   a_coloff: assert property (p_coloff) else $error("collision held on quiet pair");
   property p_eof; $stable(rx_pos_in) [*8] |-> !carrier_out; endproperty
   a_eof: assert property (p_eof) else $error("carrier held on quiet line");
endmodule
bind mcc_codec mcc_codec_assertions u_mcc_codec_assertions (.ref_clk_in, .rst_in, .tx_en_in,
   .tx_data_in, .rx_pos_in, .collision_pair_pos_in, .tx_clk_out, .tx_pos_out, .tx_neg_out,
   .rx_clk_out, .carrier_out, .collision_out, .tx_abort_out, .aui_mode_in, .col_led_out);

// *** tb/mcc_far_end.sv ***
// Purpose: far-end model driving the receive and collision pairs
// Assumes: one half-bit per reference clock, msb first
// Notes: idle pairs held equal at 0, collision tone toggles every cycle
`timescale 1ns/1ps
module mcc_far_end
(
   input  wire        clk_in,
   input  wire        load_in,
   input  wire [15:0] word_in,
   input  wire        col_en_in,
   output reg         rx_pos_out,
   output reg         rx_neg_out,
   output reg         col_pos_out,
   output reg         col_neg_out
);
   reg [15:0] sh_r = 16'h0000;
   reg [5:0]  n_r  = 6'h00;
   initial {rx_pos_out, rx_neg_out, col_pos_out, col_neg_out} = 4'h0;
   always @(posedge clk_in)
   begin
      // odd count is the second half, so a one rises at mid-bit
      rx_pos_out <= (n_r != 6'h00) & (n_r[0] ~^ sh_r[15]);
      rx_neg_out <= (n_r != 6'h00) & (n_r[0] ^ sh_r[15]);
      col_pos_out <= col_en_in & ~col_pos_out;
      col_neg_out <= col_en_in & col_pos_out;
      if (load_in)
         {sh_r, n_r} <= {word_in, 6'h20};
      else if (n_r != 6'h00)
         {sh_r, n_r} <= {(n_r[0] ? {sh_r[14:0], 1'b0} : sh_r), n_r - 6'h01};
   end
endmodule

// *** tb/tb.sv ***
// Purpose: self-checking bench for the manchester codec
// Assumes: far-end model on the receive and collision pairs
// Notes: outputs are read at the edge, before that edge's updates land
`timescale 1ns/1ps
module tb;
   reg        clk = 1'b0, rst = 1'b1, tx_en = 1'b0, tx_d = 1'b0, load = 1'b0, col_en = 1'b0;
   reg        d, prev, seen, cs, aui = 1'b1;
   reg [15:0] word = 16'h0000;
   reg [31:0] r;
   reg [7:0]  sh;
   integer    n_mismatch = 0, checked = 0, i;
   wire       rxp, rxn, cp, cn, tck, tp, tn, rck, rd, rv, car, col, abt, led;
   mcc_far_end u_mcc_far_end (.clk_in(clk), .load_in(load), .word_in(word), .col_en_in(col_en),
      .rx_pos_out(rxp), .rx_neg_out(rxn), .col_pos_out(cp), .col_neg_out(cn));
   mcc_codec u_mcc_codec (.ref_clk_in(clk), .rst_in(rst), .aui_mode_in(aui), .tx_en_in(tx_en),
      .tx_data_in(tx_d), .rx_pos_in(rxp), .rx_neg_in(rxn), .collision_pair_pos_in(cp),
      .collision_pair_neg_in(cn), .tx_clk_out(tck), .tx_pos_out(tp), .tx_neg_out(tn),
      .rx_clk_out(rck), .rx_data_out(rd), .rx_valid_out(rv), .carrier_out(car),
      .collision_out(col), .tx_abort_out(abt), .col_led_out(led));
   always #25 clk = ~clk;
   function e_half(input b, input second); e_half = second ? b : ~b; endfunction
   task chk(input got, input exp);
   begin
      checked = checked + 1;
      if (got !== exp)
      begin
         n_mismatch = n_mismatch + 1;
         $display("[ERR] %0t got %b expected %b", $time, got, exp);
      end
   end
   endtask
   task finish_test;
   begin
      $display("checked %0d n_mismatch %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   end
   endtask
   initial
   begin
      r = $urandom(32'hE304AAAD);
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      while (tck !== 1'b1) @(posedge clk);
      // back-to-back bits, the last slot with enable low
      for (i = 0; i < 17; i = i + 1)
      begin
         r = $urandom;
         d = r[0];
         tx_d <= d;
         tx_en <= (i < 16);
         @(posedge clk);
         if (i > 0) chk(tp, e_half(prev, 1'b1));
         @(posedge clk);
         chk(tn, (i < 16) & d);
         chk(tp, (i < 16) & ~d);
         prev = d;
      end
      $display("transmit test done");
      r = $urandom;
      word <= {8'hAA, r[7:0]};
      load <= 1'b1;
      @(posedge clk);
      load <= 1'b0;
      seen = 1'b0;
      cs = 1'b0;
      repeat (60)
      begin
         @(posedge clk);
         if (rck === 1'b1) sh = {sh[6:0], rd};
         if (rv === 1'b1) seen = 1'b1;
         if (car === 1'b1) cs = 1'b1;
      end
      chk(seen, 1'b1);
      chk(cs, 1'b1);
      for (i = 0; i < 8; i = i + 1) chk(sh[i], r[i]);
      chk(car, 1'b0);
      $display("receive test done");
      tx_en <= 1'b1;
      col_en <= 1'b1;
      // the abort flag stands for one cycle, so it is caught while it stands
      seen = 1'b0;
      repeat (10)
      begin
         @(posedge clk);
         if (abt === 1'b1) seen = 1'b1;
      end
      chk(col, 1'b1);
      chk(seen, 1'b1);
      chk(tp | tn, 1'b0);
      chk(led, 1'b1);
      tx_en <= 1'b0;
      @(posedge clk);
      col_en <= 1'b0;
      repeat (20) @(posedge clk);
      // heartbeat: tone with no transmit and no carrier keeps the indicator dark
      col_en <= 1'b1;
      repeat (10) @(posedge clk);
      chk(col, 1'b1);
      chk(led, 1'b0);
      col_en <= 1'b0;
      $display("collision test done");
      // outside attachment mode a collision neither aborts nor lights the indicator
      repeat (20) @(posedge clk);
      aui <= 1'b0;
      tx_en <= 1'b1;
      col_en <= 1'b1;
      seen = 1'b0;
      repeat (10)
      begin
         @(posedge clk);
         if (abt === 1'b1) seen = 1'b1;
      end
      chk(col, 1'b1);
      chk(seen, 1'b0);
      chk(led, 1'b0);
      chk(tp ^ tn, 1'b1);
      // drop the request only at a bit boundary
      while (tck !== 1'b1) @(posedge clk);
      tx_en <= 1'b0;
      col_en <= 1'b0;
      @(posedge clk);
      $display("attachment-off test done");
      finish_test;
   end
   initial
   begin
      #100000;
      n_mismatch = n_mismatch + 1;
      $display("[ERR] %0t watchdog expired", $time);
      finish_test;
   end
endmodule
